// ### rtl/acs_pkg.sv
// Constants, field layouts and carrier types for the axis correction and sync start block
package acs_pkg;
  // Register word offsets on the plain register port
  localparam logic [7:0] OFS_CORR_CFG = 8'h00;
  localparam logic [7:0] OFS_CNT_CFG = 8'h04;
  localparam logic [7:0] OFS_VIB_TIME = 8'h08;
  localparam logic [7:0] OFS_OP_MODE = 8'h0C;
  localparam logic [7:0] OFS_SYNC_CFG = 8'h10;
  localparam logic [7:0] OFS_CORR_SPEED = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_IRQ_STS = 8'h1C;
  localparam logic [7:0] OFS_EXT_STS = 8'h20;
  localparam logic [7:0] OFS_COMMAND = 8'h24;

  // Field positions
  localparam int CORR_AMT_LSB = 0;
  localparam int CORR_METH_LSB = 12;
  localparam int CNT_EN_LSB = 16;
  localparam int VIB_REV_LSB = 0;
  localparam int VIB_FWD_LSB = 16;
  localparam int MSY_LSB = 18;
  localparam int MAX_LSB = 20;
  localparam int SYO_LSB = 16;
  localparam int SYI_LSB = 20;
  localparam int IRQ_LSB = 4;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_DIR_BIT = 1;

  // Counts of clock cycles
  localparam int VIB_UNIT_SHIFT = 5;
  localparam int VIB_UNIT_CYCLES = 1 << VIB_UNIT_SHIFT;

  // Values after reset
  localparam logic [11:0] CORR_AMT_RST = 12'h000;
  localparam logic [15:0] VIB_TIME_RST = 16'h0000;
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [8:0] IRQ_RST = 9'h000;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [1:0] FIELD2_RST = 2'h0;

  // Correction methods
  localparam logic [1:0] METH_OFF = 2'h0;
  localparam logic [1:0] METH_BACKLASH = 2'h1;
  localparam logic [1:0] METH_SLIP = 2'h2;

  // Synchronous start methods and trigger axes
  localparam logic [1:0] MSY_SYNC_SIG = 2'h2;
  localparam logic [1:0] MSY_AXIS_STOP = 2'h3;
  localparam logic [1:0] MAX_X = 2'h1;
  localparam logic [1:0] MAX_Y = 2'h2;
  localparam logic [1:0] SYI_X = 2'h0;
  localparam logic [1:0] SYI_Y = 2'h1;

  // Sync output timing codes
  localparam logic [3:0] SYO_CMP1 = 4'h1;
  localparam logic [3:0] SYO_CMP2 = 4'h2;
  localparam logic [3:0] SYO_CMP3 = 4'h3;
  localparam logic [3:0] SYO_CMP4 = 4'h4;
  localparam logic [3:0] SYO_CMP5 = 4'h5;
  localparam logic [3:0] SYO_ACC_START = 4'h8;
  localparam logic [3:0] SYO_ACC_DONE = 4'h9;
  localparam logic [3:0] SYO_DEC_START = 4'hA;
  localparam logic [3:0] SYO_DEC_DONE = 4'hB;

  // Operation status codes
  localparam logic [3:0] STS_IDLE = 4'h0;
  localparam logic [3:0] STS_RUN = 4'h1;
  localparam logic [3:0] STS_WAIT_SYNC = 4'h3;
  localparam logic [3:0] STS_WAIT_STOP = 4'h4;
  localparam logic [3:0] STS_CORR = 4'h5;
  localparam logic [3:0] STS_VIB = 4'h6;

  // Profile and comparator events, one-cycle pulses, MSB first as in the cause bits
  typedef struct packed {
    logic [4:0] cmp;
    logic decel_done;
    logic decel_start;
    logic accel_done;
    logic accel_start;
  } acs_evt_t;

  // Pulse train toward the motor driver
  typedef struct packed {
    logic pulse;
    logic dir;
  } acs_pulse_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_SYNC,
    ST_WAIT_STOP,
    ST_PREP,
    ST_CORR,
    ST_RUN,
    ST_VIB_REV,
    ST_VIB_FWD
  } acs_state_t;
endpackage

// ### rtl/acs_top.sv
// Per-axis correction pulses, vibration restriction and synchronous start logic
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Correction emits programmed pulse count at set rate
// - Backlash corrects whenever travel direction changes
// - Slip corrects before every operation
// - Correction amount is 12 bits, 0..4095
// - Method field: off, backlash, slip
// - Four counter enables choose correction counting
// - After operation, one reverse then forward pulse
// - Restriction only when both timings nonzero
// - Reverse timing in bits 0..15
// - Forward timing in bits 16..31
// - One timing count is 32 clocks
// - Start method: sync signal or other stop
// - Trigger axis: X stop or Y stop
// - Sync out on comparators 1 to 5
// - Sync out on profile events 1000..1011
// - Other timing codes disable sync out
// - Interrupt fires together with sync signal
// - Software reads event cause and status
// - Sync input taken from X or Y
// - Status shows 0011 and 0100 waits
// - Only observed run-to-stop edge triggers start
module acs_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input acs_pkg::acs_evt_t evt,
  input wire logic cmd_pulse,
  input wire logic cmd_busy,
  input wire logic x_running,
  input wire logic y_running,
  input wire logic sync_in_x,
  input wire logic sync_in_y,
  output acs_pkg::acs_pulse_t motor,
  output logic run_start,
  output logic [3:0] corr_count,
  output logic sync_out,
  output logic irq
);

  // Configuration registers
  logic [11:0] correction_amount_q;
  logic [1:0] correction_method_q;
  logic [3:0] corr_count_en_q;
  logic [15:0] reverse_delay_q;
  logic [15:0] forward_delay_q;
  logic [1:0] sync_start_method_q;
  logic [1:0] trigger_axis_select_q;
  logic [3:0] sync_out_timing_q;
  logic [1:0] sync_in_source_q;
  logic [15:0] correction_speed_q;
  logic [8:0] irq_en_q;
  logic [8:0] irq_sts_q;
  logic [8:0] irq_sts_d;

  // Sequencer state
  acs_pkg::acs_state_t state_q, state_d;
  logic [11:0] rem_q, rem_d;
  logic [20:0] tmr_q, tmr_d;
  logic cmd_dir_q, cmd_dir_d;
  logic last_dir_q, last_dir_d;
  logic busy_seen_q, busy_seen_d;
  logic pulse_d;
  logic dir_d;
  logic start_d;
  logic corr_fire;
  logic prev_run_q;
  logic [3:0] corr_count_d;
  logic [31:0] rdata_d;
  logic [3:0] op_status;
  logic sync_fire;
  logic [8:0] evt_vec;

  // Address decode
  wire wr_corr = reg_wr && (reg_addr == acs_pkg::OFS_CORR_CFG);
  wire wr_cnt = reg_wr && (reg_addr == acs_pkg::OFS_CNT_CFG);
  wire wr_vib = reg_wr && (reg_addr == acs_pkg::OFS_VIB_TIME);
  wire wr_mode = reg_wr && (reg_addr == acs_pkg::OFS_OP_MODE);
  wire wr_sync = reg_wr && (reg_addr == acs_pkg::OFS_SYNC_CFG);
  wire wr_speed = reg_wr && (reg_addr == acs_pkg::OFS_CORR_SPEED);
  wire wr_irq_en = reg_wr && (reg_addr == acs_pkg::OFS_IRQ_EN);
  wire wr_irq_sts = reg_wr && (reg_addr == acs_pkg::OFS_IRQ_STS);
  wire wr_cmd = reg_wr && (reg_addr == acs_pkg::OFS_COMMAND);
  wire start_cmd = wr_cmd && reg_wdata[acs_pkg::CMD_START_BIT];

  // Vibration restriction armed only with both delays nonzero
  wire vib_en = (reverse_delay_q != 16'h0000) && (forward_delay_q != 16'h0000);

  // Delays in clock cycles, 32 per count, minus the cycle spent loading
  wire [20:0] rev_cycles = ({5'h00, reverse_delay_q} << acs_pkg::VIB_UNIT_SHIFT)
                           - 21'h000001;
  wire [20:0] fwd_cycles = ({5'h00, forward_delay_q} << acs_pkg::VIB_UNIT_SHIFT)
                           - 21'h000001;

  // Correction pulse spacing: high one cycle, then correction_speed + 1 low cycles
  wire [20:0] corr_gap = {5'h00, correction_speed_q} + 21'h000001;

  // Correction needed for the operation about to start
  wire backlash_hit = (correction_method_q == acs_pkg::METH_BACKLASH)
                      && (cmd_dir_q != last_dir_q);
  wire slip_hit = (correction_method_q == acs_pkg::METH_SLIP);
  wire need_corr = (backlash_hit || slip_hit) && (correction_amount_q != 12'h000);

  // Trigger axis stop observation; the waiting axis itself is never running
  wire sel_running = (trigger_axis_select_q == acs_pkg::MAX_X) ? x_running :
                     (trigger_axis_select_q == acs_pkg::MAX_Y) ? y_running : 1'b0;
  wire stop_edge = prev_run_q && !sel_running;

  // Internal synchronous input source
  wire sync_in = (sync_in_source_q == acs_pkg::SYI_X) ? sync_in_x :
                 (sync_in_source_q == acs_pkg::SYI_Y) ? sync_in_y : 1'b0;

  assign evt_vec = evt;

  // Sync output timing select; unassigned codes keep the output off
  always_comb begin
    case (sync_out_timing_q)
      acs_pkg::SYO_CMP1: sync_fire = evt.cmp[0];
      acs_pkg::SYO_CMP2: sync_fire = evt.cmp[1];
      acs_pkg::SYO_CMP3: sync_fire = evt.cmp[2];
      acs_pkg::SYO_CMP4: sync_fire = evt.cmp[3];
      acs_pkg::SYO_CMP5: sync_fire = evt.cmp[4];
      acs_pkg::SYO_ACC_START: sync_fire = evt.accel_start;
      acs_pkg::SYO_ACC_DONE: sync_fire = evt.accel_done;
      acs_pkg::SYO_DEC_START: sync_fire = evt.decel_start;
      acs_pkg::SYO_DEC_DONE: sync_fire = evt.decel_done;
      default: sync_fire = 1'b0;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    rem_d = rem_q;
    tmr_d = tmr_q;
    cmd_dir_d = cmd_dir_q;
    last_dir_d = last_dir_q;
    busy_seen_d = busy_seen_q;
    pulse_d = 1'b0;
    dir_d = motor.dir;
    start_d = 1'b0;
    corr_fire = 1'b0;
    case (state_q)
      acs_pkg::ST_IDLE: begin
        if (start_cmd) begin
          cmd_dir_d = reg_wdata[acs_pkg::CMD_DIR_BIT];
          if (sync_start_method_q == acs_pkg::MSY_SYNC_SIG) begin
            state_d = acs_pkg::ST_WAIT_SYNC;
          end else if (sync_start_method_q == acs_pkg::MSY_AXIS_STOP) begin
            state_d = acs_pkg::ST_WAIT_STOP;
          end else begin
            state_d = acs_pkg::ST_PREP;
          end
        end
      end
      acs_pkg::ST_WAIT_SYNC: begin
        if (sync_in) begin
          state_d = acs_pkg::ST_PREP;
        end
      end
      acs_pkg::ST_WAIT_STOP: begin
        if (stop_edge) begin
          state_d = acs_pkg::ST_PREP;
        end
      end
      acs_pkg::ST_PREP: begin
        if (need_corr) begin
          rem_d = correction_amount_q;
          tmr_d = 21'h000000;
          state_d = acs_pkg::ST_CORR;
        end else begin
          start_d = 1'b1;
          last_dir_d = cmd_dir_q;
          busy_seen_d = 1'b0;
          state_d = acs_pkg::ST_RUN;
        end
      end
      acs_pkg::ST_CORR: begin
        if (rem_q == 12'h000) begin
          start_d = 1'b1;
          last_dir_d = cmd_dir_q;
          busy_seen_d = 1'b0;
          state_d = acs_pkg::ST_RUN;
        end else if (tmr_q == 21'h000000) begin
          pulse_d = 1'b1;
          dir_d = cmd_dir_q;
          corr_fire = 1'b1;
          rem_d = rem_q - 12'h001;
          tmr_d = corr_gap;
        end else begin
          tmr_d = tmr_q - 21'h000001;
        end
      end
      acs_pkg::ST_RUN: begin
        pulse_d = cmd_pulse;
        dir_d = cmd_dir_q;
        if (cmd_busy) begin
          busy_seen_d = 1'b1;
        end
        if (busy_seen_q && !cmd_busy) begin
          if (vib_en) begin
            tmr_d = rev_cycles;
            state_d = acs_pkg::ST_VIB_REV;
          end else begin
            state_d = acs_pkg::ST_IDLE;
          end
        end
      end
      acs_pkg::ST_VIB_REV: begin
        if (tmr_q == 21'h000000) begin
          pulse_d = 1'b1;
          dir_d = !last_dir_q;
          tmr_d = fwd_cycles;
          state_d = acs_pkg::ST_VIB_FWD;
        end else begin
          tmr_d = tmr_q - 21'h000001;
        end
      end
      acs_pkg::ST_VIB_FWD: begin
        if (tmr_q == 21'h000000) begin
          pulse_d = 1'b1;
          dir_d = last_dir_q;
          state_d = acs_pkg::ST_IDLE;
        end else begin
          tmr_d = tmr_q - 21'h000001;
        end
      end
      default: state_d = acs_pkg::ST_IDLE;
    endcase
  end

  // Per-counter strobes for correction pulses
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cnt
      assign corr_count_d[gi] = corr_fire && corr_count_en_q[gi];
    end
  endgenerate

  // Status code visible to software
  always_comb begin
    case (state_q)
      acs_pkg::ST_WAIT_SYNC: op_status = acs_pkg::STS_WAIT_SYNC;
      acs_pkg::ST_WAIT_STOP: op_status = acs_pkg::STS_WAIT_STOP;
      acs_pkg::ST_CORR: op_status = acs_pkg::STS_CORR;
      acs_pkg::ST_PREP: op_status = acs_pkg::STS_CORR;
      acs_pkg::ST_RUN: op_status = acs_pkg::STS_RUN;
      acs_pkg::ST_VIB_REV: op_status = acs_pkg::STS_VIB;
      acs_pkg::ST_VIB_FWD: op_status = acs_pkg::STS_VIB;
      default: op_status = acs_pkg::STS_IDLE;
    endcase
  end

  // Sticky causes: a new event beats a write-one clear in the same cycle
  assign irq_sts_d = (irq_sts_q & ~(wr_irq_sts ? reg_wdata[acs_pkg::IRQ_LSB +: 9] : 9'h000))
                     | evt_vec;

  // Read data; write-only configuration reads as zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        acs_pkg::OFS_IRQ_EN: rdata_d[acs_pkg::IRQ_LSB +: 9] = irq_en_q;
        acs_pkg::OFS_IRQ_STS: rdata_d[acs_pkg::IRQ_LSB +: 9] = irq_sts_q;
        acs_pkg::OFS_EXT_STS: rdata_d[3:0] = op_status;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Configuration register writes
  always_ff @(posedge clock) begin
    if (!resetn) begin
      correction_amount_q <= acs_pkg::CORR_AMT_RST;
      correction_method_q <= acs_pkg::METH_OFF;
      corr_count_en_q <= acs_pkg::NIB_RST;
      reverse_delay_q <= acs_pkg::VIB_TIME_RST;
      forward_delay_q <= acs_pkg::VIB_TIME_RST;
      sync_start_method_q <= acs_pkg::FIELD2_RST;
      trigger_axis_select_q <= acs_pkg::FIELD2_RST;
      sync_out_timing_q <= acs_pkg::NIB_RST;
      sync_in_source_q <= acs_pkg::FIELD2_RST;
      correction_speed_q <= acs_pkg::SPEED_RST;
      irq_en_q <= acs_pkg::IRQ_RST;
    end else begin
      if (wr_corr) begin
        correction_amount_q <= reg_wdata[acs_pkg::CORR_AMT_LSB +: 12];
        correction_method_q <= reg_wdata[acs_pkg::CORR_METH_LSB +: 2];
      end
      if (wr_cnt) begin
        corr_count_en_q <= reg_wdata[acs_pkg::CNT_EN_LSB +: 4];
      end
      if (wr_vib) begin
        reverse_delay_q <= reg_wdata[acs_pkg::VIB_REV_LSB +: 16];
        forward_delay_q <= reg_wdata[acs_pkg::VIB_FWD_LSB +: 16];
      end
      if (wr_mode) begin
        sync_start_method_q <= reg_wdata[acs_pkg::MSY_LSB +: 2];
        trigger_axis_select_q <= reg_wdata[acs_pkg::MAX_LSB +: 2];
      end
      if (wr_sync) begin
        sync_out_timing_q <= reg_wdata[acs_pkg::SYO_LSB +: 4];
        sync_in_source_q <= reg_wdata[acs_pkg::SYI_LSB +: 2];
      end
      if (wr_speed) begin
        correction_speed_q <= reg_wdata[15:0];
      end
      if (wr_irq_en) begin
        irq_en_q <= reg_wdata[acs_pkg::IRQ_LSB +: 9];
      end
    end
  end

  // Sequencer and pulse outputs
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_q <= acs_pkg::ST_IDLE;
      rem_q <= 12'h000;
      tmr_q <= 21'h000000;
      cmd_dir_q <= 1'b0;
      last_dir_q <= 1'b0;
      busy_seen_q <= 1'b0;
      motor <= '0;
      run_start <= 1'b0;
      corr_count <= 4'h0;
    end else begin
      state_q <= state_d;
      rem_q <= rem_d;
      tmr_q <= tmr_d;
      cmd_dir_q <= cmd_dir_d;
      last_dir_q <= last_dir_d;
      busy_seen_q <= busy_seen_d;
      motor.pulse <= pulse_d;
      motor.dir <= dir_d;
      run_start <= start_d;
      corr_count <= corr_count_d;
    end
  end

  // Events, interrupt and read port; irq and sync_out rise on the same edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_sts_q <= acs_pkg::IRQ_RST;
      prev_run_q <= 1'b0;
      sync_out <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      irq_sts_q <= irq_sts_d;
      prev_run_q <= sel_running;
      sync_out <= sync_fire;
      irq <= |(irq_sts_d & irq_en_q);
      reg_rdata <= rdata_d;
    end
  end

endmodule

// ### verif/acs_motor_model.sv
// Behavioural motor driver that tallies step pulses by direction and timing
`timescale 1ns/1ps
module acs_motor_model (
  input wire logic clock,
  input acs_pkg::acs_pulse_t motor
);
  int n_pos = 0;
  int n_neg = 0;
  int cyc = 0;
  int t_prev = 0;
  int t_last = 0;
  // Sampled mid-cycle so the registered step line has settled; dir 1 is negative
  always @(negedge clock) begin
    cyc++;
    if (motor.pulse === 1'b1) begin
      t_prev = t_last;
      t_last = cyc;
      if (motor.dir === 1'b1) n_neg++;
      else n_pos++;
    end
  end
endmodule

// ### verif/acs_top_props.sv
// Concurrent checks on the ports of the correction and sync start block
`timescale 1ns/1ps
module acs_top_props (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input acs_pkg::acs_evt_t evt,
  input acs_pkg::acs_pulse_t motor,
  input wire logic run_start,
  input wire logic [3:0] corr_count,
  input wire logic sync_out,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [31:0] irq_en_q;
  logic [3:0] sync_code_q;
  wire logic code_off;
  // Shadows of the interrupt enable and sync timing registers, taken from the write strobes
  always_ff @(posedge clock) begin
    if (!resetn) irq_en_q <= 32'h0;
    else if (reg_wr && reg_addr == acs_pkg::OFS_IRQ_EN) irq_en_q <= reg_wdata;
  end
  always_ff @(posedge clock) begin
    if (!resetn) sync_code_q <= 4'h0;
    else if (reg_wr && reg_addr == acs_pkg::OFS_SYNC_CFG) sync_code_q <= reg_wdata[19:16];
  end
  // Unassigned timing codes
  assign code_off = !(sync_code_q inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB});

  corr_strobe_a: assert property (corr_count != 4'h0 |-> motor.pulse)
    else $error("Counter strobe without a step pulse");
  corr_spacing_a: assert property (corr_count != 4'h0 |=> !motor.pulse)
    else $error("Correction pulses closer than the minimum spacing");
  start_once_a: assert property (run_start |=> !run_start)
    else $error("Start strobe longer than one cycle");
  sync_cause_a: assert property (sync_out |-> $past(evt) != 9'h0)
    else $error("Sync output without an event");
  sync_off_a: assert property (code_off |=> !sync_out)
    else $error("Sync output while its timing code is off");
  sync_cmp_a: assert property (evt.cmp[0] && sync_code_q == acs_pkg::SYO_CMP1 |=> sync_out)
    else $error("Comparator one event gave no sync output");
  sync_accel_a: assert property (evt.accel_start && sync_code_q == acs_pkg::SYO_ACC_START |=> sync_out)
    else $error("Acceleration start gave no sync output");
  irq_follow_a: assert property ((evt & irq_en_q[12:4]) != 9'h0 |=> irq)
    else $error("Enabled event did not raise the interrupt");
  irq_cause_a: assert property ($rose(irq) |-> $past(evt) != 9'h0 || $past(reg_wr))
    else $error("Interrupt rose without a cause");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("Read data outside the answer cycle");
endmodule

bind acs_top acs_top_props u_props (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .motor(motor),
  .run_start(run_start), .corr_count(corr_count), .sync_out(sync_out), .irq(irq)
);

// ### verif/test_axis_correction_sync_start.sv
// Self-checking bench for correction, restriction and sync start
`timescale 1ns/1ps
module test_axis_correction_sync_start;
  logic clock, resetn, reg_wr, reg_rd, cmd_pulse, cmd_busy, rd_seen;
  logic x_running, y_running, sync_in_x, sync_in_y, run_start, sync_out, irq;
  logic [7:0] reg_addr, lf;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0] corr_count, en;
  logic [1:0] meth;
  acs_pkg::acs_evt_t evt;
  acs_pkg::acs_pulse_t motor;
  logic [31:0] exp_q[$];
  int fails = 0;
  int n_compared = 0;
  int cc_n, nn, np, k, i, idx, amt, m;
  logic [3:0] codes [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'h6};

  acs_top dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evt(evt), .cmd_pulse(cmd_pulse),
    .cmd_busy(cmd_busy), .x_running(x_running), .y_running(y_running), .sync_in_x(sync_in_x),
    .sync_in_y(sync_in_y), .motor(motor), .run_start(run_start), .corr_count(corr_count),
    .sync_out(sync_out), .irq(irq));
  acs_motor_model drv (.clock(clock), .motor(motor));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Strobes get a gap cycle so a task never lowers and raises at one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask

  // Answer stands only in the cycle after the strobe; strobes must match enables
  always @(negedge clock) begin
    if (rd_seen) check("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_seen = reg_rd;
    if (corr_count !== 4'h0) begin
      cc_n++;
      check("corr_count", {28'h0, en}, {28'h0, corr_count});
    end
  end

  // Waits for the start strobe, then plays the main generator for mp pulses
  task automatic run_op(input int mp, input int w);
    for (k = 0; k < 300 && run_start !== 1'b1; k++) @(negedge clock);
    check("run_start", 32'h1, {31'h0, run_start});
    @(posedge clock);
    cmd_busy <= 1'b1;
    repeat (mp) begin
      @(posedge clock);
      cmd_pulse <= 1'b1;
      @(posedge clock);
      cmd_pulse <= 1'b0;
    end
    @(posedge clock);
    cmd_busy <= 1'b0;
    repeat (w + 8) @(posedge clock);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    report_and_stop;
  end

  initial begin
    {resetn, reg_wr, reg_rd, cmd_pulse, cmd_busy, rd_seen} = 6'h0;
    {x_running, y_running, sync_in_x, sync_in_y} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    evt = '0;
    lf = 8'h3F;
    cc_n = 0;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rd(acs_pkg::OFS_EXT_STS, {28'h0, acs_pkg::STS_IDLE});
    rd(acs_pkg::OFS_CORR_CFG, 32'h0);
    rd(8'hFC, 32'h0);
    // Reversal corrects, a repeat does not, slip always corrects
    lf = lfsr(lf);
    amt = int'(lf[2:0]) + 1;
    m = int'(lf[4:3]);
    en = lf[7:4] | 4'h1;
    wr(acs_pkg::OFS_CORR_SPEED, {30'h0, lf[1:0]});
    wr(acs_pkg::OFS_CNT_CFG, {12'h0, en, 16'h0});
    for (i = 0; i < 3; i++) begin
      meth = (i == 2) ? acs_pkg::METH_SLIP : acs_pkg::METH_BACKLASH;
      wr(acs_pkg::OFS_CORR_CFG, {18'h0, meth, amt[11:0]});
      nn = drv.n_neg;
      cc_n = 0;
      wr(acs_pkg::OFS_COMMAND, 32'h3);
      run_op(m, 0);
      check("neg_pulses", 32'((i == 1) ? m : amt + m), 32'(drv.n_neg - nn));
      check("corr_strobes", 32'((i == 1) ? 0 : amt), 32'(cc_n));
    end
    $display("test correction done");
    // One reverse then one forward pulse, only with both delays set
    wr(acs_pkg::OFS_CORR_CFG, 32'h0);
    wr(acs_pkg::OFS_VIB_TIME, 32'h00020001);
    nn = drv.n_neg;
    np = drv.n_pos;
    wr(acs_pkg::OFS_COMMAND, 32'h1);
    run_op(1, 100);
    check("rev_pulses", 32'h1, 32'(drv.n_neg - nn));
    check("fwd_pulses", 32'h2, 32'(drv.n_pos - np));
    check("fwd_gap", 32'h40, 32'(drv.t_last - drv.t_prev));
    wr(acs_pkg::OFS_VIB_TIME, 32'h00000001);
    nn = drv.n_neg;
    wr(acs_pkg::OFS_COMMAND, 32'h1);
    run_op(1, 100);
    check("no_restrict", 32'h0, 32'(drv.n_neg - nn));
    $display("test restriction done");
    // Start on X stopping; a Y stop must not count
    wr(acs_pkg::OFS_OP_MODE, 32'h001C0000);
    wr(acs_pkg::OFS_COMMAND, 32'h1);
    rd(acs_pkg::OFS_EXT_STS, {28'h0, acs_pkg::STS_WAIT_STOP});
    y_running <= 1'b1;
    repeat (3) @(posedge clock);
    y_running <= 1'b0;
    x_running <= 1'b1;
    repeat (3) @(posedge clock);
    rd(acs_pkg::OFS_EXT_STS, {28'h0, acs_pkg::STS_WAIT_STOP});
    x_running <= 1'b0;
    run_op(0, 0);
    // Same with the Y axis as the trigger
    wr(acs_pkg::OFS_OP_MODE, 32'h002C0000);
    wr(acs_pkg::OFS_COMMAND, 32'h1);
    y_running <= 1'b1;
    @(posedge clock);
    y_running <= 1'b0;
    run_op(0, 0);
    // Start on the Y sync signal; the X one must not count
    wr(acs_pkg::OFS_SYNC_CFG, 32'h00100000);
    wr(acs_pkg::OFS_OP_MODE, 32'h00080000);
    wr(acs_pkg::OFS_COMMAND, 32'h1);
    rd(acs_pkg::OFS_EXT_STS, {28'h0, acs_pkg::STS_WAIT_SYNC});
    sync_in_x <= 1'b1;
    @(posedge clock);
    sync_in_x <= 1'b0;
    rd(acs_pkg::OFS_EXT_STS, {28'h0, acs_pkg::STS_WAIT_SYNC});
    sync_in_y <= 1'b1;
    @(posedge clock);
    sync_in_y <= 1'b0;
    run_op(0, 0);
    wr(acs_pkg::OFS_OP_MODE, 32'h0);
    $display("test sync start done");
    // Every timing code with its event, plus one unassigned code
    wr(acs_pkg::OFS_IRQ_EN, 32'h00001FF0);
    for (i = 0; i < 10; i++) begin
      idx = (codes[i] <= 4'h5) ? int'(codes[i]) + 3 : (codes[i] >= 4'h8 ? int'(codes[i]) - 8 : 0);
      wr(acs_pkg::OFS_SYNC_CFG, {12'h0, codes[i], 16'h0});
      @(posedge clock);
      evt <= acs_pkg::acs_evt_t'(9'h1 << idx);
      @(posedge clock);
      evt <= '0;
      @(negedge clock);
      check("sync_out", {31'h0, i < 9}, {31'h0, sync_out});
      check("irq", 32'h1, {31'h0, irq});
      rd(acs_pkg::OFS_IRQ_STS, 32'h10 << idx);
      wr(acs_pkg::OFS_IRQ_STS, 32'h10 << idx);
    end
    @(negedge clock);
    check("irq_cleared", 32'h0, {31'h0, irq});
    $display("test sync output done");
    report_and_stop;
  end
endmodule
